// *** design/an_status_pkg.sv ***
// Constants and carrier types for the negotiation status register bank
package an_status_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0]  ADDR_PARTNER_ABILITY = 5'h05;
    localparam logic [4:0]  ADDR_EXPANSION       = 5'h06;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_NEXT_PAGE      = 15;
    localparam int BIT_ACK            = 14;
    localparam int BIT_MESSAGE_PAGE   = 13;
    localparam int BIT_CAN_COMPLY     = 12;
    localparam int BIT_TOGGLE         = 11;
    localparam int EXP_BIT_PD_FAULT   = 4;
    localparam int EXP_BIT_LP_NP      = 3;
    localparam int EXP_BIT_LOCAL_NP   = 2;
    localparam int EXP_BIT_PAGE_RX    = 1;
    localparam int EXP_BIT_LP_AN      = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_PARTNER_ABILITY = 16'h0000;
    localparam logic [10:0] RESET_CODE            = 11'h000;
    localparam logic        LOCAL_NP_VALUE        = 1'b1;

    // Next page word received from the partner
    typedef struct packed {
        logic        next_page;
        logic        ack;
        logic        message_page_flag;
        logic        partner_can_comply;
        logic        toggle;
        logic [10:0] code;
    } next_page_word_s;

    // Register port request
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

endpackage

// *** design/in_sync.sv ***
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module in_sync
    import an_status_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_stage1   = clk_en ? async_in : stage1;
        next_sync_out = clk_en ? stage1 : sync_out;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// *** design/read_port.sv ***
// Register read multiplexer with one-cycle registered read data
`timescale 1ns/1ps
`default_nettype none
module read_port
    import an_status_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    input  wire logic        rd,
    input  wire logic [4:0]  addr,
    input  wire logic [15:0] ability_value,
    input  wire logic [15:0] expansion_value,
    output logic      [15:0] rdata
);
    logic [15:0] next_rdata;

    always_comb begin
        next_rdata = rdata;
        if (clk_en) begin
            next_rdata = 16'h0000;
            if (rd) begin
                case (addr)
                    ADDR_PARTNER_ABILITY: next_rdata = ability_value;
                    ADDR_EXPANSION:       next_rdata = expansion_value;
                    default:              next_rdata = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// *** design/an_status_regs.sv ***
// Negotiation next page partner ability and expansion status registers
`timescale 1ns/1ps
`default_nettype none
module an_status_regs
    import an_status_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    input  wire logic            clk_en,
    input  wire logic [4:0]      reg_addr,
    input  wire logic [15:0]     reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [15:0]     reg_rdata,
    input  wire logic            page_valid,
    input  wire next_page_word_s page_word,
    input  wire logic            ack_update,
    input  wire logic            ack_value,
    input  wire logic            pd_fault_in,
    input  wire logic            partner_np_in,
    input  wire logic            partner_an_in,
    output logic                 page_received
);
    // ------------------------------------------------------------
    // Status levels from the negotiation logic
    // ------------------------------------------------------------
    logic [2:0] status_sync;

    in_sync #(.W(3)) u_status_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in ({pd_fault_in, partner_np_in, partner_an_in}),
        .sync_out (status_sync)
    );

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    next_page_word_s ability;
    next_page_word_s next_ability;
    logic            pd_fault;
    logic            next_pd_fault;
    logic            partner_np;
    logic            next_partner_np;
    logic            partner_an;
    logic            next_partner_an;
    logic            next_page_received;
    logic            exp_read;
    logic [15:0]     ability_value;
    logic [15:0]     expansion_value;

    // Writes change nothing: both registers are read-only
    assign exp_read = clk_en && reg_rd && (reg_addr == ADDR_EXPANSION);

    always_comb begin
        next_ability       = ability;
        next_pd_fault      = pd_fault;
        next_partner_np    = partner_np;
        next_partner_an    = partner_an;
        next_page_received = page_received;
        if (clk_en) begin
            next_pd_fault   = status_sync[2];
            next_partner_np = status_sync[1];
            next_partner_an = status_sync[0];
            if (ack_update) begin
                next_ability.ack = ack_value;
            end
            if (page_valid) begin
                next_ability = page_word;
            end
            if (exp_read) begin
                next_page_received = 1'b0;
            end
            if (page_valid) begin
                next_page_received = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ability       <= RESET_PARTNER_ABILITY;
            pd_fault      <= 1'b0;
            partner_np    <= 1'b0;
            partner_an    <= 1'b0;
            page_received <= 1'b0;
        end else begin
            ability       <= next_ability;
            pd_fault      <= next_pd_fault;
            partner_np    <= next_partner_np;
            partner_an    <= next_partner_an;
            page_received <= next_page_received;
        end
    end

    // ------------------------------------------------------------
    // Read values
    // ------------------------------------------------------------
    always_comb begin
        ability_value                   = 16'h0000;
        ability_value[BIT_NEXT_PAGE]    = ability.next_page;
        ability_value[BIT_ACK]          = ability.ack;
        ability_value[BIT_MESSAGE_PAGE] = ability.message_page_flag;
        ability_value[BIT_CAN_COMPLY]   = ability.partner_can_comply;
        ability_value[BIT_TOGGLE]       = ability.toggle;
        ability_value[10:0]             = ability.code;
        expansion_value                   = 16'h0000;
        expansion_value[EXP_BIT_PD_FAULT] = pd_fault;
        expansion_value[EXP_BIT_LP_NP]    = partner_np;
        expansion_value[EXP_BIT_LOCAL_NP] = LOCAL_NP_VALUE;
        expansion_value[EXP_BIT_PAGE_RX]  = page_received;
        expansion_value[EXP_BIT_LP_AN]    = partner_an;
    end

    read_port u_read_port (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .clk_en          (clk_en),
        .rd              (reg_rd),
        .addr            (reg_addr),
        .ability_value   (ability_value),
        .expansion_value (expansion_value),
        .rdata           (reg_rdata)
    );

    // reg_wdata and reg_wr are accepted and ignored (read-only bank)
    logic unused_wr;
    assign unused_wr = reg_wr ^ (^reg_wdata);
endmodule
`default_nettype wire

// *** sim/an_status_assertions.sv ***
// Port checker for the negotiation status register bank
`timescale 1ns/1ps
`default_nettype none
module an_status_assertions
    import an_status_pkg::*;
(
    input wire logic            sys_clk,
    input wire logic            reset_n,
    input wire logic            clk_en,
    input wire logic [4:0]      reg_addr,
    input wire logic [15:0]     reg_wdata,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [15:0]     reg_rdata,
    input wire logic            page_valid,
    input wire next_page_word_s page_word,
    input wire logic            ack_update,
    input wire logic            ack_value,
    input wire logic            pd_fault_in,
    input wire logic            partner_np_in,
    input wire logic            partner_an_in,
    input wire logic            page_received
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire rd5   = clk_en && reg_rd && reg_addr == ADDR_PARTNER_ABILITY;
    wire rd6   = clk_en && reg_rd && reg_addr == ADDR_EXPANSION;
    wire quiet = !page_valid && !ack_update;
    wire [2:0] st = {pd_fault_in, partner_np_in, partner_an_in};
    AST_FIXED: assert property (rd6 |=> reg_rdata[15:5] == 11'h000 && reg_rdata[2]) else $error("fixed bits");
    AST_SET: assert property (clk_en && page_valid |=> page_received) else $error("page flag not set");
    AST_CLR: assert property (rd6 && !page_valid |=> !page_received) else $error("page flag kept");
    AST_LOAD: assert property (clk_en && page_valid ##1 (rd5 && quiet) |=> reg_rdata == $past(page_word, 2))
        else $error("page word not loaded");
    AST_ACK: assert property (clk_en && ack_update && !page_valid ##1 (rd5 && quiet)
        |=> reg_rdata[14] == $past(ack_value, 2)) else $error("ack not updated");
    AST_STAT: assert property ((clk_en && $stable(st))[*5] ##0 rd6
        |=> {reg_rdata[4:3], reg_rdata[0]} == $past(st)) else $error("status bits");
    AST_WR: assert property (clk_en && reg_wr && !reg_rd && !page_valid |=> $stable(page_received))
        else $error("write changed flag");
    AST_IDLE: assert property (clk_en && !rd5 && !rd6 |=> reg_rdata == 16'h0000) else $error("idle data");
    AST_FREEZE: assert property (!clk_en |=> $stable(reg_rdata) && $stable(page_received))
        else $error("state moved while frozen");
endmodule
bind an_status_regs an_status_assertions an_status_assertions_i (.sys_clk, .reset_n, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .page_valid, .page_word, .ack_update, .ack_value,
    .pd_fault_in, .partner_np_in, .partner_an_in, .page_received);
`default_nettype wire

// *** sim/np_partner.sv ***
// Model of the negotiation logic and link partner feeding the bank
`timescale 1ns/1ps
`default_nettype none
module np_partner
    import an_status_pkg::*;
(
    input  wire logic           sys_clk,
    output var logic            page_valid,
    output var next_page_word_s page_word,
    output var logic            ack_update,
    output var logic            ack_value,
    output var logic            pd_fault_in,
    output var logic            partner_np_in,
    output var logic            partner_an_in
);
    initial begin
        {page_valid, ack_update, ack_value} = 3'h0;
        {pd_fault_in, partner_np_in, partner_an_in} = 3'h0;
        page_word = 16'h5555;
    end
    // Idle word shows the inverse of the last one
    task automatic send_page(input logic [15:0] w);
        @(posedge sys_clk);
        page_valid <= 1'b1;
        page_word  <= w;
        @(posedge sys_clk);
        page_valid <= 1'b0;
        page_word  <= ~w;
    endtask
    task automatic send_ack(input logic v);
        @(posedge sys_clk);
        ack_update <= 1'b1;
        ack_value  <= v;
        @(posedge sys_clk);
        ack_update <= 1'b0;
        ack_value  <= ~v;
    endtask
    task automatic set_status(input logic [2:0] s);
        @(posedge sys_clk);
        {pd_fault_in, partner_np_in, partner_an_in} <= s;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the negotiation status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb
    import an_status_pkg::*;
;
    logic            sys_clk;
    logic            reset_n;
    logic            clk_en;
    logic            reg_wr;
    logic            reg_rd;
    logic [4:0]      reg_addr;
    logic [15:0]     reg_wdata;
    wire logic [15:0] reg_rdata;
    wire logic       page_valid, ack_update, ack_value, pd_f, p_np, p_an, page_received;
    wire next_page_word_s page_word;
    int              errors;
    int              checked;
    an_status_regs an_status_regs_i (.sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .page_valid, .page_word, .ack_update, .ack_value, .pd_fault_in(pd_f),
        .partner_np_in(p_np), .partner_an_in(p_an), .page_received);
    np_partner np_partner_i (.sys_clk, .page_valid, .page_word, .ack_update, .ack_value,
        .pd_fault_in(pd_f), .partner_np_in(p_np), .partner_an_in(p_an));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #20000;
        errors++;
        stop_test;
    end
    initial begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        clk_en  = 1'b1;
        errors  = 0;
        checked = 0;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(5'h05, RESET_PARTNER_ABILITY);
        rd(5'h06, 16'h0004);
        $display("reset test done");
        np_partner_i.set_status(3'h5);
        rd(5'h06, 16'h0015);
        np_partner_i.set_status(3'h2);
        rd(5'h06, 16'h000c);
        $display("status test done");
        np_partner_i.send_page(16'hb5a5);
        #1 `CHK(page_received, 1'b1)
        rd(5'h05, 16'hb5a5);
        rd(5'h06, 16'h000e);
        rd(5'h06, 16'h000c);
        fork
            np_partner_i.send_ack(1'b1);
            begin
                @(posedge sys_clk);
                rd(5'h05, 16'hf5a5);
            end
        join
        $display("page test done");
        wr(5'h06, 16'hffff);
        wr(5'h05, 16'h0000);
        rd(5'h06, 16'h000c);
        rd(5'h05, 16'hf5a5);
        rd(5'h1f, 16'h0000);
        $display("write test done");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        np_partner_i.send_page(16'h1234);
        clk_en <= 1'b1;
        #1 `CHK(page_received, 1'b0)
        rd(5'h05, 16'hf5a5);
        $display("freeze test done");
        fork
            np_partner_i.send_page(16'h4a5a);
            begin
                @(posedge sys_clk);
                rd(5'h05, 16'h4a5a);
            end
        join
        fork
            rd(5'h06, 16'h000e);
            np_partner_i.send_page(16'h07ff);
        join
        rd(5'h06, 16'h000e);
        rd(5'h05, 16'h07ff);
        $display("second page test done");
        np_partner_i.send_page(16'h2001);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        #1 `CHK(page_received, 1'b0)
        rd(5'h05, RESET_PARTNER_ABILITY);
        $display("reset again test done");
        stop_test;
    end
endmodule
`default_nettype wire
